// ### include/wit_params.svh
// Constants for the watchdog and interval timer
`ifndef WIT_PARAMS_SVH
`define WIT_PARAMS_SVH

// Register addresses on the internal bus
`define WIT_ADDR_CTRL    16'hFF74
`define WIT_ADDR_CNT     16'hFF75
`define WIT_ADDR_RST_WR  16'hFF76
`define WIT_ADDR_RST_RD  16'hFF77

// Write keys in the upper byte of a word write
`define WIT_KEY_CNT      8'h5A
`define WIT_KEY_CSR      8'hA5

// Reset values and reserved bits
`define WIT_ZERO8        8'h00
`define WIT_CNT_MAX      8'hFF
`define WIT_RCTL_INIT    8'h1F
`define WIT_CSR_RSVD     2'h3
`define WIT_RST_RSVD     5'h1F

// Field positions
`define WIT_IFLAG_BIT    7
`define WIT_MODE_BIT     6
`define WIT_RUN_BIT      5
`define WIT_CKS_HI       2
`define WIT_CKS_LO       0
`define WIT_WFLAG_BIT    7
`define WIT_ROUT_BIT     6
`define WIT_RKIND_BIT    5

// Prescaler width and tap shifts (divider is two to the shift)
`define WIT_PRE_W        17
`define WIT_TAP0_SH      1
`define WIT_TAP1_SH      6
`define WIT_TAP2_SH      7
`define WIT_TAP3_SH      9
`define WIT_TAP4_SH      11
`define WIT_TAP5_SH      13
`define WIT_TAP6_SH      15
`define WIT_TAP7_SH      17
`define WIT_TAPS         8

// Internal reset pulse in system clock states
`define WIT_PULSE_W      10
`define WIT_PULSE_CYC    10'h206

`endif

// ### include/wit_pkg.sv
// Types shared by the watchdog and interval timer
package wit_pkg;

  // Internal reset pulse generator states
  typedef enum logic [0:0]
  {
    WIT_PS_IDLE   = 1'h0,
    WIT_PS_ACTIVE = 1'h1
  } wit_pulse_state_t;

  // Counter operating mode
  typedef enum logic [0:0]
  {
    WIT_MODE_INTERVAL = 1'h0,
    WIT_MODE_WATCHDOG = 1'h1
  } wit_mode_t;

endpackage

// ### hdl/wit_prescaler.sv
// Free-running prescaler with eight divider taps
`timescale 1ns/10ps
`include "wit_params.svh"

module wit_prescaler
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  output logic [`WIT_TAPS-1:0]      tapTick
);

  logic [`WIT_PRE_W-1:0] preCnt_ff;
  logic [`WIT_PRE_W-1:0] nxt_preCnt;

  // Shift of each tap
  function automatic int tapShift(input int idx);
    case (idx)
      0:       tapShift = `WIT_TAP0_SH;
      1:       tapShift = `WIT_TAP1_SH;
      2:       tapShift = `WIT_TAP2_SH;
      3:       tapShift = `WIT_TAP3_SH;
      4:       tapShift = `WIT_TAP4_SH;
      5:       tapShift = `WIT_TAP5_SH;
      6:       tapShift = `WIT_TAP6_SH;
      default: tapShift = `WIT_TAP7_SH;
    endcase
  endfunction

  // Divider advances every clock
  always_comb
  begin
    nxt_preCnt = preCnt_ff + `WIT_PRE_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      preCnt_ff <= '0;
    else
      preCnt_ff <= nxt_preCnt;
  end

  // One pulse per divider period on each tap
  genvar gi;
  generate
    for (gi = 0; gi < `WIT_TAPS; gi++)
    begin : gTap
      localparam int SH = tapShift(gi);
      assign tapTick[gi] = &preCnt_ff[SH-1:0];
    end
  endgenerate

endmodule

// ### hdl/wit_reset_pulse.sv
// Stretches a watchdog overflow into the internal reset pulse
`timescale 1ns/10ps
`include "wit_params.svh"

module wit_reset_pulse
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  start,
  input  wire logic  kindIn,
  output logic       active,
  output logic       kind
);

  wit_pkg::wit_pulse_state_t state_ff;
  wit_pkg::wit_pulse_state_t nxt_state;
  logic [`WIT_PULSE_W-1:0]   cnt_ff;
  logic [`WIT_PULSE_W-1:0]   nxt_cnt;
  logic                      kind_ff;
  logic                      nxt_kind;
  logic [`WIT_PULSE_W-1:0]   lenCnt_ff;

  // Pulse sequencing
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_kind  = kind_ff;
    case (state_ff)
      wit_pkg::WIT_PS_IDLE:
      begin
        if (start)
        begin
          nxt_state = wit_pkg::WIT_PS_ACTIVE;
          nxt_cnt   = `WIT_PULSE_CYC - `WIT_PULSE_W'(1);
          nxt_kind  = kindIn;
        end
      end
      wit_pkg::WIT_PS_ACTIVE:
      begin
        if (cnt_ff == '0)
          nxt_state = wit_pkg::WIT_PS_IDLE;
        else
          nxt_cnt = cnt_ff - `WIT_PULSE_W'(1);
      end
      default:
        nxt_state = wit_pkg::WIT_PS_IDLE;
    endcase
  end

  // External pin reset overrides any pulse
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_ff <= wit_pkg::WIT_PS_IDLE;
      cnt_ff   <= '0;
      kind_ff  <= 1'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      kind_ff  <= nxt_kind;
    end
  end

  assign active = (state_ff == wit_pkg::WIT_PS_ACTIVE);
  assign kind   = kind_ff;

  // Length of the pulse, for checking only
  always_ff @(posedge clk)
  begin
    if (!rst_n || !active)
      lenCnt_ff <= '0;
    else
      lenCnt_ff <= lenCnt_ff + `WIT_PULSE_W'(1);
  end

  pulse_length_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      $fell(active) && $past(rst_n) |-> $past(lenCnt_ff) == `WIT_PULSE_CYC - `WIT_PULSE_W'(1))
    else $error("internal reset pulse length wrong");

endmodule

// ### hdl/wit_watchdog_interval_timer.sv
// Watchdog and interval timer with key-protected registers
`timescale 1ns/10ps
`include "wit_params.svh"

module wit_watchdog_interval_timer
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         busSel,
  input  wire logic         busWr,
  input  wire logic         busWord,
  input  wire logic [15:0]  busAddr,
  input  wire logic [15:0]  busWdata,
  output logic      [7:0]   busRdata,
  output logic              busRdValid,
  output logic              intervalTimerIrq,
  output logic              chipResetReq,
  output logic              chipResetKind,
  output logic              watchdogOverflowFlag
);

  // ****************************************************
  // Declarations
  // ****************************************************
  logic [`WIT_TAPS-1:0] tapTick;
  logic                 tick;
  logic [7:0]           keyByte;
  logic [7:0]           dataByte;
  logic                 wrCtrl;
  logic                 wrCnt;
  logic                 wrCsr;
  logic                 wrRst;
  logic                 rstClr;
  logic                 rstCfg;
  logic                 rdCsr;
  logic                 rdRst;
  logic                 rollEvent;
  logic                 wdRoll;

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic       ivFlag_ff;
  logic       nxt_ivFlag;
  logic       ivArm_ff;
  logic       nxt_ivArm;
  wit_pkg::wit_mode_t mode_ff;
  wit_pkg::wit_mode_t nxt_mode;
  logic       run_ff;
  logic       nxt_run;
  logic [2:0] cks_ff;
  logic [2:0] nxt_cks;

  logic       wdFlag_ff;
  logic       nxt_wdFlag;
  logic       wdArm_ff;
  logic       nxt_wdArm;
  logic       rstOutEn_ff;
  logic       nxt_rstOutEn;
  logic       rstKind_ff;
  logic       nxt_rstKind;

  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       rdValid_ff;
  logic       nxt_rdValid;

  // Tap picked by the clock select code
  function automatic logic tapSelect(input logic [`WIT_TAPS-1:0] taps, input logic [2:0] code);
    tapSelect = taps[code];
  endfunction

  // Bus address match for a protected register
  function automatic logic addrHit(input logic [15:0] addr, input logic [15:0] reg_addr);
    addrHit = (addr == reg_addr);
  endfunction

  // ****************************************************
  // Submodules
  // ****************************************************

  // Divider taps of the system clock
  wit_prescaler u_prescaler
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .tapTick (tapTick)
  );

  // Chip-wide internal reset pulse
  wit_reset_pulse u_reset_pulse
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (wdRoll && rstOutEn_ff),
    .kindIn (rstKind_ff),
    .active (chipResetReq),
    .kind   (chipResetKind)
  );

  // ****************************************************
  // Bus decode
  // ****************************************************

  // Keyed word writes only; byte writes fall through
  assign keyByte  = busWdata[15:8];
  assign dataByte = busWdata[7:0];
  assign wrCtrl   = busSel && busWr && busWord && addrHit(busAddr, `WIT_ADDR_CTRL);
  assign wrCnt    = wrCtrl && (keyByte == `WIT_KEY_CNT);
  assign wrCsr    = wrCtrl && (keyByte == `WIT_KEY_CSR);
  assign wrRst    = busSel && busWr && busWord && addrHit(busAddr, `WIT_ADDR_RST_WR);
  assign rstClr   = wrRst && (keyByte == `WIT_KEY_CSR) && (dataByte == `WIT_ZERO8);
  assign rstCfg   = wrRst && (keyByte == `WIT_KEY_CNT);
  assign rdCsr    = busSel && !busWr && addrHit(busAddr, `WIT_ADDR_CTRL);
  assign rdRst    = busSel && !busWr && addrHit(busAddr, `WIT_ADDR_RST_RD);

  // Overflow events; a counter write in the same cycle wins
  assign tick     = run_ff && tapSelect(tapTick, cks_ff);
  assign rollEvent = tick && !wrCnt && (cnt_ff == `WIT_CNT_MAX);
  assign wdRoll    = rollEvent && (mode_ff == wit_pkg::WIT_MODE_WATCHDOG);

  // ****************************************************
  // Counter and timer control register
  // ****************************************************

  // Next counter and control state
  always_comb
  begin
    nxt_cnt    = cnt_ff;
    nxt_ivFlag = ivFlag_ff;
    nxt_ivArm  = ivArm_ff;
    nxt_mode   = mode_ff;
    nxt_run    = run_ff;
    nxt_cks    = cks_ff;
    if (!run_ff)
      nxt_cnt = `WIT_ZERO8;
    else if (wrCnt)
      nxt_cnt = dataByte;
    else if (tick)
      nxt_cnt = cnt_ff + 8'h01;
    if (wrCsr)
    begin
      nxt_mode = wit_pkg::wit_mode_t'(dataByte[`WIT_MODE_BIT]);
      nxt_run  = dataByte[`WIT_RUN_BIT];
      nxt_cks  = dataByte[`WIT_CKS_HI:`WIT_CKS_LO];
      if (ivArm_ff && !dataByte[`WIT_IFLAG_BIT])
        nxt_ivFlag = 1'h0;
      nxt_ivArm = 1'h0;
    end
    if (rdCsr && ivFlag_ff)
      nxt_ivArm = 1'h1;
    if (rollEvent)
      nxt_ivFlag = 1'h1;
    if (wdRoll)
    begin
      nxt_cnt    = `WIT_ZERO8;
      nxt_ivFlag = 1'h0;
      nxt_ivArm  = 1'h0;
      nxt_mode   = wit_pkg::WIT_MODE_INTERVAL;
      nxt_run    = 1'h0;
      nxt_cks    = 3'h0;
    end
  end

  // Counter and control registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_ff    <= `WIT_ZERO8;
      ivFlag_ff <= 1'h0;
      ivArm_ff  <= 1'h0;
      mode_ff   <= wit_pkg::WIT_MODE_INTERVAL;
      run_ff    <= 1'h0;
      cks_ff    <= 3'h0;
    end
    else
    begin
      cnt_ff    <= nxt_cnt;
      ivFlag_ff <= nxt_ivFlag;
      ivArm_ff  <= nxt_ivArm;
      mode_ff   <= nxt_mode;
      run_ff    <= nxt_run;
      cks_ff    <= nxt_cks;
    end
  end

  // ****************************************************
  // Reset control register
  // ****************************************************

  // Next reset control state
  always_comb
  begin
    nxt_wdFlag   = wdFlag_ff;
    nxt_wdArm    = wdArm_ff;
    nxt_rstOutEn = rstOutEn_ff;
    nxt_rstKind  = rstKind_ff;
    if (rstClr)
    begin
      if (wdArm_ff)
        nxt_wdFlag = 1'h0;
      nxt_wdArm = 1'h0;
    end
    if (rdRst && wdFlag_ff)
      nxt_wdArm = 1'h1;
    if (rstCfg)
    begin
      nxt_rstOutEn = dataByte[`WIT_ROUT_BIT];
      nxt_rstKind  = dataByte[`WIT_RKIND_BIT];
    end
    if (wdRoll)
      nxt_wdFlag = 1'h1;
  end

  // Only the pin reset initialises this register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wdFlag_ff   <= 1'(`WIT_RCTL_INIT >> `WIT_WFLAG_BIT);
      wdArm_ff    <= 1'h0;
      rstOutEn_ff <= 1'h0;
      rstKind_ff  <= 1'h0;
    end
    else
    begin
      wdFlag_ff   <= nxt_wdFlag;
      wdArm_ff    <= nxt_wdArm;
      rstOutEn_ff <= nxt_rstOutEn;
      rstKind_ff  <= nxt_rstKind;
    end
  end

  // ****************************************************
  // Read data
  // ****************************************************

  // Read mux, one cycle after the strobe
  always_comb
  begin
    nxt_rdValid = busSel && !busWr;
    nxt_rdata   = `WIT_ZERO8;
    if (rdCsr)
      nxt_rdata = {ivFlag_ff, mode_ff, run_ff, `WIT_CSR_RSVD, cks_ff};
    else if (busSel && !busWr && addrHit(busAddr, `WIT_ADDR_CNT))
      nxt_rdata = cnt_ff;
    else if (rdRst)
      nxt_rdata = {wdFlag_ff, rstOutEn_ff, rstKind_ff, `WIT_RST_RSVD};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdata_ff   <= `WIT_ZERO8;
      rdValid_ff <= 1'h0;
    end
    else
    begin
      rdata_ff   <= nxt_rdata;
      rdValid_ff <= nxt_rdValid;
    end
  end

  // Outputs
  assign busRdata             = rdata_ff;
  assign busRdValid           = rdValid_ff;
  assign intervalTimerIrq     = ivFlag_ff && (mode_ff == wit_pkg::WIT_MODE_INTERVAL);
  assign watchdogOverflowFlag = wdFlag_ff;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seqWdRollRst;
    wdRoll && rstOutEn_ff;
  endsequence

  sequence seqCsrArm;
    rdCsr && ivFlag_ff;
  endsequence

  run_off_zero_a:
    assert property (!run_ff |=> cnt_ff == `WIT_ZERO8)
    else $error("counter not zero while stopped");

  count_step_a:
    assert property (tick && !wrCnt |=> cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("counter missed a tap step");

  flag_set_a:
    assert property (rollEvent && mode_ff == wit_pkg::WIT_MODE_INTERVAL |=> ivFlag_ff)
    else $error("overflow flag not set");

  flag_hold_a:
    assert property (ivFlag_ff && !ivArm_ff && !wdRoll |=> ivFlag_ff)
    else $error("overflow flag cleared without read");

  flag_clear_seq_a:
    assert property (seqCsrArm ##1 !wrCsr ##1 (wrCsr && !dataByte[`WIT_IFLAG_BIT] && !rollEvent) |=> !ivFlag_ff)
    else $error("armed zero write did not clear flag");

  self_reset_a:
    assert property (wdRoll |=> !ivFlag_ff && !run_ff && cnt_ff == `WIT_ZERO8 && mode_ff == wit_pkg::WIT_MODE_INTERVAL)
    else $error("watchdog overflow left timer running");

  pin_reset_init_a:
    assert property (@(posedge clk) disable iff (1'h0)
      !rst_n |=> !mode_ff && !wdFlag_ff && !rstOutEn_ff && !rstKind_ff && !chipResetReq)
    else $error("pin reset values wrong");

  reserved_read_a:
    assert property (rdCsr |=> busRdValid && busRdata[4:3] == `WIT_CSR_RSVD)
    else $error("reserved control bits not one");

  wd_flag_mode_a:
    assert property ($rose(wdFlag_ff) |-> $past(mode_ff) == wit_pkg::WIT_MODE_WATCHDOG)
    else $error("watchdog flag set in interval mode");

  wd_flag_hold_a:
    assert property (wdFlag_ff && !(rstClr && wdArm_ff) |=> wdFlag_ff)
    else $error("watchdog flag lost");

  chip_reset_a:
    assert property (seqWdRollRst |=> chipResetReq [*8])
    else $error("internal reset not issued");

  no_chip_reset_a:
    assert property (wdRoll && !rstOutEn_ff && !chipResetReq |=> !chipResetReq)
    else $error("chip reset without enable");

  reset_kind_a:
    assert property (seqWdRollRst |=> chipResetKind == $past(rstKind_ff))
    else $error("internal reset kind wrong");

  irq_follow_a:
    assert property (rollEvent && mode_ff == wit_pkg::WIT_MODE_INTERVAL |=> intervalTimerIrq)
    else $error("interval interrupt not raised");

  bad_key_a:
    assert property (busSel && busWr && !wrCnt && !wrCsr && !wrRst && run_ff && !tick
                     |=> $stable(cnt_ff) && $stable(mode_ff) && $stable(cks_ff))
    else $error("unkeyed write changed state");

endmodule

// ### testbench/wit_cpu_model.sv
// CPU-side model driving the timer's internal register bus
`timescale 1ns/10ps

module wit_cpu_model
(
  input  wire logic         clk,
  input  wire logic [7:0]   busRdata,
  input  wire logic         busRdValid,
  output logic              busSel,
  output logic              busWr,
  output logic              busWord,
  output logic      [15:0]  busAddr,
  output logic      [15:0]  busWdata
);
  // Idle bus at time zero
  initial
  begin
    busSel   = 1'h0;
    busWr    = 1'h0;
    busWord  = 1'h0;
    busAddr  = 16'h0000;
    busWdata = 16'h0000;
  end

  // One strobe cycle, then release with scrambled lines
  task automatic acc(input logic wr, input logic word, input logic [15:0] addr,
                     input logic [15:0] wdata, output logic [7:0] rdata);
    @(negedge clk);
    busSel   = 1'h1;
    busWr    = wr;
    busWord  = word;
    busAddr  = addr;
    busWdata = wdata;
    @(negedge clk);
    rdata    = (busRdValid === 1'h1) ? busRdata : 8'hXX;
    busSel   = 1'h0;
    busWr    = ~wr;
    busWord  = ~word;
    busAddr  = ~addr;
    busWdata = ~wdata;
  endtask

  // Word write: key in upper byte, data in lower byte
  task automatic wr(input logic [15:0] addr, input logic [7:0] key, input logic [7:0] data);
    logic [7:0] unused;
    acc(1'h1, 1'h1, addr, {key, data}, unused);
  endtask

  // Byte-wide write, refused by the protected registers
  task automatic wrByte(input logic [15:0] addr, input logic [7:0] key, input logic [7:0] data);
    logic [7:0] unused;
    acc(1'h1, 1'h0, addr, {key, data}, unused);
  endtask

  // Byte read
  task automatic rd(input logic [15:0] addr, output logic [7:0] data);
    acc(1'h0, 1'h0, addr, 16'h0000, data);
  endtask

  // Flag poll: two reads before any clearing write
  task automatic poll(input logic [15:0] addr, output logic [7:0] data);
    rd(addr, data);
    rd(addr, data);
  endtask
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the watchdog and interval timer
`timescale 1ns/10ps
`include "wit_params.svh"

module tb_top;
  logic         clk = 1'h0;
  logic         rst_n;
  logic         busSel;
  logic         busWr;
  logic         busWord;
  logic [15:0]  busAddr;
  logic [15:0]  busWdata;
  logic [7:0]   busRdata;
  logic         busRdValid;
  logic         intervalTimerIrq;
  logic         chipResetReq;
  logic         chipResetKind;
  logic         watchdogOverflowFlag;
  int           nErrors;
  int           checkCount;
  int           n;
  logic [7:0]   rd;
  int           divTbl [8] = '{2, 64, 128, 512, 2048, 8192, 32768, 131072};

  // 25 MHz clock
  always #20 clk = ~clk;

  wit_watchdog_interval_timer u_wit_watchdog_interval_timer
  (
    .clk                  (clk),
    .rst_n                (rst_n),
    .busSel               (busSel),
    .busWr                (busWr),
    .busWord              (busWord),
    .busAddr              (busAddr),
    .busWdata             (busWdata),
    .busRdata             (busRdata),
    .busRdValid           (busRdValid),
    .intervalTimerIrq     (intervalTimerIrq),
    .chipResetReq         (chipResetReq),
    .chipResetKind        (chipResetKind),
    .watchdogOverflowFlag (watchdogOverflowFlag)
  );

  wit_cpu_model u_wit_cpu_model
  (
    .clk        (clk),
    .busRdata   (busRdata),
    .busRdValid (busRdValid),
    .busSel     (busSel),
    .busWr      (busWr),
    .busWord    (busWord),
    .busAddr    (busAddr),
    .busWdata   (busWdata)
  );

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Exact compare
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp)
    begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Range compare
  task automatic chkRange(input string what, input logic [15:0] lo, input logic [15:0] hi,
                          input logic [15:0] got);
    checkCount++;
    if ((got >= lo && got <= hi) !== 1'h1)
    begin
      nErrors++;
      $display("wrong value %s expected %h to %h seen %h", what, lo, hi, got);
    end
  endtask

  // Bus shorthands
  task automatic rdChk(input logic [15:0] addr, input logic [7:0] exp);
    u_wit_cpu_model.rd(addr, rd);
    chk($sformatf("reg %h", addr), exp, rd);
  endtask

  task automatic wr(input logic [15:0] addr, input logic [7:0] key, input logic [7:0] data);
    u_wit_cpu_model.wr(addr, key, data);
  endtask

  // Arm watchdog mode on the fastest tap and let it overflow
  task automatic wdRun(input logic [7:0] rstBits);
    wr(`WIT_ADDR_RST_WR, `WIT_KEY_CNT, rstBits);
    wr(`WIT_ADDR_CTRL, `WIT_KEY_CSR, 8'h60);
    wr(`WIT_ADDR_CTRL, `WIT_KEY_CNT, 8'hF8);
    for (n = 0; n < 40 && watchdogOverflowFlag !== 1'h1; n++)
      @(negedge clk);
  endtask

  // Hang guard
  initial
  begin
    repeat (90000) @(negedge clk);
    nErrors++;
    summarize();
  end

  // Main sequence
  initial
  begin
    nErrors    = 0;
    checkCount = 0;
    rst_n      = 1'h0;
    repeat (4) @(negedge clk);
    rst_n = 1'h1;
    rdChk(`WIT_ADDR_CTRL, 8'h18);
    rdChk(`WIT_ADDR_CNT, 8'h00);
    rdChk(`WIT_ADDR_RST_RD, 8'h1F);
    rdChk(16'hFF70, 8'h00);
    // Refused and protected writes
    wr(`WIT_ADDR_CTRL, `WIT_KEY_CNT, 8'h37);
    rdChk(`WIT_ADDR_CNT, 8'h00);
    u_wit_cpu_model.wrByte(`WIT_ADDR_CTRL, `WIT_KEY_CSR, 8'h47);
    wr(`WIT_ADDR_CTRL, 8'h33, 8'h47);
    wr(`WIT_ADDR_RST_WR, 8'h33, 8'h60);
    rdChk(`WIT_ADDR_CTRL, 8'h18);
    rdChk(`WIT_ADDR_RST_RD, 8'h1F);
    wr(`WIT_ADDR_CTRL, `WIT_KEY_CSR, 8'h47);
    rdChk(`WIT_ADDR_CTRL, 8'h5F);
    wr(`WIT_ADDR_CTRL, `WIT_KEY_CSR, 8'h27);
    wr(`WIT_ADDR_CTRL, `WIT_KEY_CNT, 8'h37);
    rdChk(`WIT_ADDR_CNT, 8'h37);
    // Refused writes while the counter runs on the slowest tap
    wr(`WIT_ADDR_CTRL, 8'h33, 8'h47);
    u_wit_cpu_model.wrByte(`WIT_ADDR_CTRL, `WIT_KEY_CNT, 8'h11);
    rdChk(`WIT_ADDR_CNT, 8'h37);
    rdChk(`WIT_ADDR_CTRL, 8'h3F);
    wr(`WIT_ADDR_CTRL, `WIT_KEY_CSR, 8'h07);
    rdChk(`WIT_ADDR_CNT, 8'h00);
    // Count rate of every tap code
    for (int c = 0; c < 8; c++)
    begin
      wr(`WIT_ADDR_CTRL, `WIT_KEY_CSR, 8'h20 | c[7:0]);
      repeat ((c < 6) ? 2 * divTbl[c] : 16384) @(negedge clk);
      u_wit_cpu_model.rd(`WIT_ADDR_CNT, rd);
      chkRange($sformatf("ticks code %0d", c), (c < 6) ? 16'h0002 : 16'h0000,
               (c < 6) ? 16'h0003 : 16'h0001, {8'h00, rd});
      wr(`WIT_ADDR_CTRL, `WIT_KEY_CSR, 8'h00);
    end
    // Interval overflow period, flag and request
    wr(`WIT_ADDR_CTRL, `WIT_KEY_CSR, 8'h20);
    for (n = 0; n < 600 && intervalTimerIrq !== 1'h1; n++)
      @(negedge clk);
    chkRange("overflow period", 16'h01FE, 16'h0202, n[15:0]);
    chk("watchdog flag", 8'h00, {7'h00, watchdogOverflowFlag});
    u_wit_cpu_model.poll(`WIT_ADDR_CTRL, rd);
    chk("control", 8'hB8, rd);
    wr(`WIT_ADDR_CTRL, `WIT_KEY_CSR, 8'hA0);
    chk("irq", 8'h01, {7'h00, intervalTimerIrq});
    u_wit_cpu_model.poll(`WIT_ADDR_CTRL, rd);
    wr(`WIT_ADDR_CTRL, `WIT_KEY_CSR, 8'h00);
    chk("irq", 8'h00, {7'h00, intervalTimerIrq});
    rdChk(`WIT_ADDR_CTRL, 8'h18);
    // Watchdog reset of both kinds
    for (int k = 0; k < 2; k++)
    begin
      wdRun({1'h0, 1'h1, k[0], 5'h00});
      chk("reset kind", {7'h00, k[0]}, {7'h00, chipResetKind});
      chk("watchdog flag", 8'h01, {7'h00, watchdogOverflowFlag});
      for (n = 0; n < 1000 && chipResetReq === 1'h1; n++)
        @(negedge clk);
      chkRange("reset pulse", 16'h0206, 16'h0206, n[15:0]);
      rdChk(`WIT_ADDR_CTRL, 8'h18);
      rdChk(`WIT_ADDR_CNT, 8'h00);
      rdChk(`WIT_ADDR_RST_RD, {1'h1, 1'h1, k[0], 5'h1F});
      wr(`WIT_ADDR_RST_WR, `WIT_KEY_CSR, 8'h00);
      rdChk(`WIT_ADDR_RST_RD, {1'h0, 1'h1, k[0], 5'h1F});
    end
    // Pin reset in mid pulse
    wdRun(8'h40);
    repeat (10) @(negedge clk);
    rst_n = 1'h0;
    @(negedge clk);
    rst_n = 1'h1;
    chk("reset request", 8'h00, {7'h00, chipResetReq});
    chk("watchdog flag", 8'h00, {7'h00, watchdogOverflowFlag});
    rdChk(`WIT_ADDR_RST_RD, 8'h1F);
    // Overflow with chip reset disabled
    wdRun(8'h20);
    chk("watchdog flag", 8'h01, {7'h00, watchdogOverflowFlag});
    repeat (3) @(negedge clk);
    chk("reset request", 8'h00, {7'h00, chipResetReq});
    rdChk(`WIT_ADDR_CTRL, 8'h18);
    summarize();
  end
endmodule
